// ### core/cas_cfg.svh
// Purpose: constants of the channel alarm/pulse register slice
// Assumes: word index = printed offset, byte address = 4 * index
// Notes:   index[7:4] is the channel, index[3:0] the register
`ifndef CAS_CFG_SVH
`define CAS_CFG_SVH

`define CAS_NCH          14
`define CAS_PIN_W        16
`define CAS_ADDR_W       12
`define CAS_REG_MASK     4'h4
`define CAS_REG_LEVEL    4'h5
`define CAS_REG_CHG      4'h6
`define CAS_REG_FIFO     4'h7
`define CAS_REG_SEG1     4'h8
`define CAS_REG_SEG2     4'h9
`define CAS_IDX_GLB_CTL  8'he0
`define CAS_IDX_GLB_SEL  8'he5
`define CAS_GIE_BIT      0
`define CAS_OVF_SEL_BIT  7
`define CAS_SIGN_BIT     6
`define CAS_RST_BYTE     8'h00
`define CAS_RST_SEG      7'h00
`define CAS_ZERO_WORD    32'h0000_0000

`endif

// ### core/cas_chan.sv
// Purpose: one channel of alarm change status, enables and segments
// Assumes: pin inputs already synchronised by the top
// Notes:   read clear and change set meet: the set wins
`timescale 1ns/1ps
`include "cas_cfg.svh"
module cas_chan
  import cas_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  cas_if.chan                        bus,
  input  wire logic [`CAS_PIN_W-1:0] i_pins,
  output logic      [6:0]            o_seg1,
  output logic      [6:0]            o_seg2
);
  cas_byte_t level;
  cas_byte_t chg_q;
  cas_byte_t chg_d;
  cas_byte_t prev_q;
  cas_byte_t mask_q;
  cas_seg_t  seg1_q;
  cas_seg_t  seg2_q;
  logic      viol;
  logic      fifo_sel;
  logic      clr_chg;
  logic      wr_mask;
  logic      wr_seg1;
  logic      wr_seg2;

  assign viol     = bus.ovf_sel ? i_pins[3] : i_pins[2];
  assign fifo_sel = i_pins[9];
  assign level    = {i_pins[0], i_pins[1], i_pins[8] | i_pins[9], viol,
                     i_pins[4], i_pins[5], i_pins[6], i_pins[7]};
  assign clr_chg  = bus.rd & (bus.addr == `CAS_REG_CHG);
  assign chg_d    = (chg_q & ~{8{clr_chg}}) | (level ^ prev_q);
  assign wr_mask  = bus.wr & (bus.addr == `CAS_REG_MASK);
  assign wr_seg1  = bus.wr & (bus.addr == `CAS_REG_SEG1);
  assign wr_seg2  = bus.wr & (bus.addr == `CAS_REG_SEG2);
  assign bus.irq  = |(chg_q & mask_q);
  assign bus.rdata = (bus.addr == `CAS_REG_MASK)  ? mask_q :
                     (bus.addr == `CAS_REG_LEVEL) ? level :
                     (bus.addr == `CAS_REG_CHG)   ? chg_q :
                     (bus.addr == `CAS_REG_FIFO)  ? {1'b0, fifo_sel, i_pins[15:10]} :
                     (bus.addr == `CAS_REG_SEG1)  ? {1'b0, seg1_q} :
                     (bus.addr == `CAS_REG_SEG2)  ? {1'b0, seg2_q} : `CAS_RST_BYTE;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chg_q  <= `CAS_RST_BYTE;
      prev_q <= `CAS_RST_BYTE;
      mask_q <= `CAS_RST_BYTE;
      seg1_q <= `CAS_RST_SEG;
      seg2_q <= `CAS_RST_SEG;
    end else begin
      chg_q  <= chg_d;
      prev_q <= level;
      if (wr_mask) mask_q <= bus.wdata;
      if (wr_seg1) seg1_q <= bus.wdata[6:0];
      if (wr_seg2) seg2_q <= bus.wdata[6:0];
    end
  end

  assign o_seg1 = seg1_q;
  assign o_seg2 = seg2_q;
endmodule : cas_chan

// ### core/cas_if.sv
// Purpose: register strobes between the bus slave and one channel slice
// Assumes: strobes are single-cycle, qualified by channel select
// Notes:   rdata and irq are combinational from the slice
`timescale 1ns/1ps
interface cas_if;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ovf_sel;
  logic       irq;

  modport top (output wr, rd, addr, wdata, ovf_sel, input rdata, irq);
  modport chan (input wr, rd, addr, wdata, ovf_sel, output rdata, irq);
endinterface : cas_if

// ### core/cas_pkg.sv
// Purpose: shared types of the channel alarm/pulse register slice
// Assumes: constants live in cas_cfg.svh
// Notes:   none
package cas_pkg;

  typedef enum logic [0:0] {
    CAS_IDLE = 1'b0,
    CAS_RESP = 1'b1
  } cas_apb_e;

  typedef logic [7:0] cas_byte_t;
  typedef logic [6:0] cas_seg_t;

endpackage : cas_pkg

// ### core/cas_top.sv
// Purpose: APB slave over fourteen channel alarm/pulse register slices
// Assumes: 40 MHz i_mclk, alarm pins asynchronous to it
// Notes:   one wait state on every transfer
`timescale 1ns/1ps
`include "cas_cfg.svh"

module cas_top
  import cas_pkg::*;
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [`CAS_ADDR_W-1:0]   i_paddr,
  input  wire logic [31:0]              i_pwdata,
  input  wire logic [3:0]               i_pstrb,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  output logic                          o_irq,
  input  wire logic [`CAS_NCH-1:0]      i_eq_flag,
  input  wire logic [`CAS_NCH-1:0]      i_drv_mon,
  input  wire logic [`CAS_NCH-1:0]      i_line_viol,
  input  wire logic [`CAS_NCH-1:0]      i_cnt_ovf,
  input  wire logic [`CAS_NCH-1:0]      i_loop_code,
  input  wire logic [`CAS_NCH-1:0]      i_all_ones,
  input  wire logic [`CAS_NCH-1:0]      i_sig_loss,
  input  wire logic [`CAS_NCH-1:0]      i_pseudo_pat,
  input  wire logic [`CAS_NCH-1:0]      i_rx_fifo_lim,
  input  wire logic [`CAS_NCH-1:0]      i_tx_fifo_lim,
  input  wire logic [`CAS_NCH*6-1:0]    i_cable_att,
  output logic      [`CAS_NCH-1:0]      o_ovs_dir,
  output logic      [`CAS_NCH*6-1:0]    o_ovs_mag,
  output logic      [`CAS_NCH-1:0]      o_seg2_dir,
  output logic      [`CAS_NCH*6-1:0]    o_seg2_mag
);

  // ******************************************************
  // reset release
  // ******************************************************
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  localparam int PINS = `CAS_NCH * `CAS_PIN_W;

  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;

  // per channel: {att[5:0], tx, rx, qrp, los, ais, loop, ovf, lcv, dmo, eq}
  for (genvar g = 0; g < `CAS_NCH; g++) begin : g_pack
    assign pin_raw[g*`CAS_PIN_W +: `CAS_PIN_W] = {
      i_cable_att[g*6 +: 6],
      i_tx_fifo_lim[g],
      i_rx_fifo_lim[g],
      i_pseudo_pat[g],
      i_sig_loss[g],
      i_all_ones[g],
      i_loop_code[g],
      i_cnt_ovf[g],
      i_line_viol[g],
      i_drv_mon[g],
      i_eq_flag[g]
    };
  end

  // first stage feeds only the second
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
    end
  end

  // only this stage is read by the slices
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= '0;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  // ******************************************************
  // address decode
  // ******************************************************
  logic [7:0] reg_idx;
  logic [3:0] ch_num;
  logic [3:0] reg_num;
  logic       hi_zero;
  logic       ch_ok;
  logic       reg_ok;
  logic       is_glb_ctl;
  logic       is_glb_sel;
  logic       is_glb;
  logic       mapped;
  logic       ch_hit;

  // word index is the printed offset
  assign reg_idx    = i_paddr[9:2];
  assign hi_zero    = (i_paddr[`CAS_ADDR_W-1:10] == 2'b00);
  assign ch_num     = reg_idx[7:4];
  assign reg_num    = reg_idx[3:0];
  assign ch_ok      = (ch_num < 4'(`CAS_NCH));
  assign reg_ok     = (reg_num >= `CAS_REG_MASK) & (reg_num <= `CAS_REG_SEG2);
  assign is_glb_ctl = (reg_idx == `CAS_IDX_GLB_CTL);
  assign is_glb_sel = (reg_idx == `CAS_IDX_GLB_SEL);
  assign is_glb     = is_glb_ctl | is_glb_sel;
  assign ch_hit     = hi_zero & ch_ok & reg_ok;
  assign mapped     = ch_hit | (hi_zero & is_glb);

  // ******************************************************
  // APB transfer control
  // ******************************************************
  cas_apb_e state_q;
  cas_apb_e state_d;
  logic     acc_go;
  logic     done_go;
  logic     wr_go;
  logic     rd_go;
  logic     acc_ph;
  logic     st_idle;
  logic     st_resp;
  logic     lane0;

  // access phase as seen in either state
  assign acc_ph  = i_psel & i_penable;
  assign st_idle = (state_q == CAS_IDLE);
  assign st_resp = (state_q == CAS_RESP);
  // first access cycle samples data, second one completes
  assign acc_go  = acc_ph & st_idle;
  assign done_go = acc_ph & st_resp;
  // narrow registers sit in byte lane 0
  assign lane0   = i_pstrb[0];
  assign wr_go   = done_go & i_pwrite & lane0 & mapped;
  // read side effect at sampling, so cleared bits equal returned bits
  assign rd_go   = acc_go & ~i_pwrite & ch_hit;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CAS_IDLE: begin
        if (acc_go) state_d = CAS_RESP;
      end
      CAS_RESP: begin
        state_d = CAS_IDLE;
      end
    endcase
  end

  // ******************************************************
  // global registers
  // ******************************************************
  cas_byte_t glb_ctl_q;
  cas_byte_t glb_sel_q;
  logic      global_irq_enable;
  logic      ovf_sel;
  logic      wr_glb_ctl;
  logic      wr_glb_sel;

  // global bytes sit in lane 0 like the channel registers
  assign wr_glb_ctl = wr_go & is_glb_ctl;
  assign wr_glb_sel = wr_go & is_glb_sel;
  assign global_irq_enable        = glb_ctl_q[`CAS_GIE_BIT];
  assign ovf_sel    = glb_sel_q[`CAS_OVF_SEL_BIT];

  // other bits of both bytes are stored only
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      glb_ctl_q <= `CAS_RST_BYTE;
    end else if (wr_glb_ctl) begin
      glb_ctl_q <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      glb_sel_q <= `CAS_RST_BYTE;
    end else if (wr_glb_sel) begin
      glb_sel_q <= i_pwdata[7:0];
    end
  end

  // ******************************************************
  // channel slices
  // ******************************************************
  logic [7:0]         ch_rdata [`CAS_NCH];
  logic [`CAS_NCH-1:0] ch_irq;
  logic [6:0]         seg1 [`CAS_NCH];
  logic [6:0]         seg2 [`CAS_NCH];

  for (genvar g = 0; g < `CAS_NCH; g++) begin : g_ch
    logic sel;
    cas_if u_if ();

    assign sel          = (ch_num == 4'(g));
    assign u_if.wr      = wr_go & ch_hit & sel;
    assign u_if.rd      = rd_go & sel;
    assign u_if.addr    = reg_num;
    assign u_if.wdata   = i_pwdata[7:0];
    assign u_if.ovf_sel = ovf_sel;
    assign ch_rdata[g]  = u_if.rdata;
    assign ch_irq[g]    = u_if.irq;

    cas_chan u_chan (
      .i_clk   (i_mclk),
      .i_rst_n (rst_n),
      .bus     (u_if.chan),
      .i_pins  (pin_sync_q[g*`CAS_PIN_W +: `CAS_PIN_W]),
      .o_seg1  (seg1[g]),
      .o_seg2  (seg2[g])
    );

    // slices hold segments one and two of eight
    assign o_ovs_dir[g]       = seg1[g][`CAS_SIGN_BIT];
    assign o_ovs_mag[g*6 +: 6] = seg1[g][5:0];
    assign o_seg2_dir[g]       = seg2[g][`CAS_SIGN_BIT];
    assign o_seg2_mag[g*6 +: 6] = seg2[g][5:0];
  end

  // ******************************************************
  // read data select
  // ******************************************************
  cas_byte_t           ch_sel_data;
  cas_byte_t           glb_data;
  cas_byte_t           rd_byte;
  logic [31:0]         rd_word;
  logic [7:0]          rd_or [`CAS_NCH+1];
  logic [`CAS_NCH-1:0] ch_pick;

  // and-or select: no array index by an address past channel 13
  assign rd_or[0] = `CAS_RST_BYTE;
  for (genvar g = 0; g < `CAS_NCH; g++) begin : g_rd
    assign ch_pick[g] = ch_hit & (ch_num == 4'(g));
    assign rd_or[g+1] = rd_or[g] | (ch_rdata[g] & {8{ch_pick[g]}});
  end

  assign ch_sel_data = rd_or[`CAS_NCH];
  assign glb_data    = is_glb_ctl ? glb_ctl_q :
                       is_glb_sel ? glb_sel_q : `CAS_RST_BYTE;
  assign rd_byte     = (hi_zero & is_glb) ? glb_data : ch_sel_data;
  // upper lanes always read zero
  assign rd_word     = {24'h00_0000, rd_byte};

  // ******************************************************
  // interrupt
  // ******************************************************
  logic irq_any;
  logic irq_q;

  assign irq_any = global_irq_enable & (|ch_irq);

  // registered so the pin never glitches on decode
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_any;
    end
  end

  // ******************************************************
  // response registers
  // ******************************************************
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CAS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one pulse per transfer, error only with it
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_go;
      pslverr_q <= acc_go & ~mapped;
    end
  end

  // writes hold read data at zero so a stale value never leaks out
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= `CAS_ZERO_WORD;
    end else if (acc_go) begin
      prdata_q <= i_pwrite ? `CAS_ZERO_WORD : rd_word;
    end
  end

  // ******************************************************
  // outputs
  // ******************************************************
  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_irq     = irq_q;

endmodule : cas_top

// ### sim/cas_alarm_src.sv
// Purpose: alarm and cable pin source standing beyond the register slice
// Assumes: pins are plain levels, changed on the bus clock edge
// Notes:   optional delay models a slow far side
`timescale 1ns/1ps
module cas_alarm_src (
  input  wire logic        i_clk,
  output logic [9:0][13:0] o_alm,
  output logic [83:0]      o_att
);
  // ********************
  // pin drive
  // ********************
  initial begin
    o_alm = '0;
    o_att = '0;
  end

  task automatic drive(input int ch, input int k, input logic v, input int d = 0);
    repeat (d + 1) @(posedge i_clk);
    o_alm[k][ch] <= v;
  endtask : drive

  task automatic cable(input int ch, input logic [5:0] a);
    @(posedge i_clk);
    o_att[ch*6 +: 6] <= a;
  endtask : cable
endmodule : cas_alarm_src

// ### sim/cas_top_chk.sv
// Purpose: bus and segment output checks of cas_top
// Assumes: sees the top ports only
// Notes:   one wait state per transfer
`timescale 1ns/1ps
`include "cas_cfg.svh"
module cas_top_chk (
  input wire logic                  i_mclk,
  input wire logic                  i_reset_n,
  input wire logic                  i_psel,
  input wire logic                  i_penable,
  input wire logic                  i_pwrite,
  input wire logic [`CAS_ADDR_W-1:0] i_paddr,
  input wire logic [31:0]           i_pwdata,
  input wire logic [3:0]            i_pstrb,
  input wire logic [31:0]           o_prdata,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  input wire logic [`CAS_NCH-1:0]   o_ovs_dir,
  input wire logic [`CAS_NCH*6-1:0] o_ovs_mag,
  input wire logic [`CAS_NCH-1:0]   o_seg2_dir,
  input wire logic [`CAS_NCH*6-1:0] o_seg2_mag
);
  // ********************
  // checks
  // ********************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  wire [3:0] reg_w  = i_paddr[5:2];
  wire       wok_w  = i_pwrite && i_pstrb[0] && !o_pslverr && (i_paddr[11:6] == 6'h00);
  wire [6:0] wseg_w = i_pwdata[6:0];
  wire       done_w = i_psel && i_penable && o_pready;

  sequence s_take;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_done;
    i_psel && i_penable && o_pready;
  endsequence

  ready_wait_a: assert property (s_take |=> s_done)
    else $error("pready late");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  unmap_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  bit7_zero_a: assert property (done_w && !i_pwrite
    && reg_w inside {`CAS_REG_FIFO, `CAS_REG_SEG1, `CAS_REG_SEG2} |-> !o_prdata[7])
    else $error("unused bit seven set");
  seg1_out_a: assert property (done_w && wok_w && reg_w == `CAS_REG_SEG1
    |=> {o_ovs_dir[0], o_ovs_mag[5:0]} == $past(wseg_w))
    else $error("overshoot output wrong");
  seg2_out_a: assert property (done_w && wok_w && reg_w == `CAS_REG_SEG2
    |=> {o_seg2_dir[0], o_seg2_mag[5:0]} == $past(wseg_w))
    else $error("segment two output wrong");
  rdata_hold_a: assert property (!(i_psel && i_penable) |=> $stable(o_prdata))
    else $error("read data moved");
endmodule : cas_top_chk

bind cas_top cas_top_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_ovs_dir(o_ovs_dir), .o_ovs_mag(o_ovs_mag), .o_seg2_dir(o_seg2_dir),
  .o_seg2_mag(o_seg2_mag));

// ### sim/tb_cas_top.sv
// Purpose: self-checking bench of the alarm/pulse register slice
// Assumes: apb master here, alarm pins from cas_alarm_src
// Notes:   byte strobes tied on, partial writes untested
`timescale 1ns/1ps
`include "cas_cfg.svh"
module tb_cas_top import cas_pkg::*;;
  logic              clk, rst_n, psel, pen, pwr, prdy, perr, irq, e;
  logic [11:0]       paddr;
  logic [31:0]       pwd, prd, r, v, seed;
  logic [9:0][13:0]  alm;
  logic [83:0]       att, om, sm;
  logic [13:0]       od, sd;
  logic [3:0]        ch;
  logic [7:0]        m;
  logic              g;
  int                n_fail, checked, b;

  cas_top i_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .o_irq(irq), .i_eq_flag(alm[7]),
    .i_drv_mon(alm[6]), .i_rx_fifo_lim(alm[5]), .i_line_viol(alm[4]),
    .i_loop_code(alm[3]), .i_all_ones(alm[2]), .i_sig_loss(alm[1]),
    .i_pseudo_pat(alm[0]), .i_tx_fifo_lim(alm[8]), .i_cnt_ovf(alm[9]),
    .i_cable_att(att), .o_ovs_dir(od), .o_ovs_mag(om), .o_seg2_dir(sd), .o_seg2_mag(sm));
  cas_alarm_src i_far (.i_clk(clk), .o_alm(alm), .o_att(att));

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string nm);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // one wait-free edge first so no signal gets two writes in one step
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {2'b00, i, 2'b00};
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // pready ends a wait, the watchdog ends one that hangs
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] i, input logic [31:0] x);
    apb(1'b0, i, 8'h00);
    chk(r, x, $sformatf("reg %h", i));
  endtask : rdc

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // ********************
  // tests
  // ********************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial begin
    {psel, pen, pwr, paddr, pwd, n_fail, checked} = '0;
    seed = 32'd88533;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 4; i < 10; i++) rdc(8'(i) | 8'hd0, 0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      ch = (i < 2) ? 4'h0 : 4'(rnd() % 14);
      v = rnd();
      apb(1'b1, {ch, 4'h8 | 4'(i % 2)}, v[7:0]);
      @(posedge clk);
      chk(i % 2 ? {sd[ch], sm[ch*6 +: 6]} : {od[ch], om[ch*6 +: 6]}, v[6:0], "seg");
      rdc({ch, 4'h8 | 4'(i % 2)}, v[6:0]);
    end
    $display("test segments done");
    for (int j = 0; j < 4; j++) begin
      ch = 4'(rnd() % 14);
      v = rnd();
      i_far.cable(ch, v[5:0]);
      i_far.drive(ch, 5, j % 2);
      i_far.drive(ch, 8, j / 2, 2);
      apb(1'b1, {ch, 4'h7}, 8'hff);
      rdc({ch, 4'h7}, {24'h0, 1'b0, 1'(j / 2), v[5:0]});
      i_far.drive(ch, 5, 0);
      i_far.drive(ch, 8, 0);
      repeat (4) @(posedge clk);
      rdc({ch, 4'h6}, (j > 0) ? 32'h20 : 32'h0);
    end
    $display("test cable done");
    for (int k = 0; k < 10; k++) begin
      ch = 4'(rnd() % 14);
      m = 8'(rnd());
      g = (k % 3 != 0);
      b = (k < 8) ? k : 13 - k;
      apb(1'b1, 8'he0, {7'h0, g});
      apb(1'b1, 8'he5, {k == 9, 7'h0});
      apb(1'b1, {ch, 4'h4}, m);
      i_far.drive(ch, k, 1);
      repeat (6) @(posedge clk);
      chk(irq, g & m[b], "irq");
      rdc({ch, 4'h6}, 32'h1 << b);
      rdc({ch, 4'h6}, 0);
      repeat (2) @(posedge clk);
      chk(irq, 0, "irq");
      rdc({ch, 4'h5}, 32'h1 << b);
      i_far.drive(ch, k, 0);
      repeat (6) @(posedge clk);
      rdc({ch, 4'h6}, 32'h1 << b);
    end
    $display("test alarms done");
    foreach (m[i]) if (i < 3) begin
      apb(1'b0, i == 0 ? 8'h0a : i == 1 ? 8'he1 : 8'hf6, 8'h00);
      chk({r, e}, 33'h1, "unmapped");
    end
    $display("test decode done");
    stop_test();
  end
endmodule : tb_cas_top
